/* bench/cftf_ctrl_model.sv */
// Protocol controller model: mode selection pins decoded to a mode, bursts of transmit edges.
// Assumes the bench pulses start for one cycle; transmit idles recessive.
`timescale 1ns/1ps
module cftf_ctrl_model
   import cftf_pkg::*;
(
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       reset,
   // Requests from the bench
   input wire logic       enable,
   input wire logic       standby_control_n,
   input wire logic       start,
   input wire logic [3:0] edges,
   input wire logic       hold_low,
   // Towards the block
   output cftf_mode_t     mode,
   output logic           transmit_data
);
   logic [5:0] cnt;
   always_comb begin
      if (enable && standby_control_n) mode = CFTF_MODE_NORMAL;
      else if (enable) mode = CFTF_MODE_GOTOSLEEP;
      else if (standby_control_n) mode = CFTF_MODE_SILENT;
      else mode = CFTF_MODE_STANDBY;
   end
   // Two cycles per level, since the block resynchronises transmit
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) cnt <= 6'h0;
      else if (start) cnt <= {edges, 2'h0};
      else if (cnt != 6'h0) cnt <= cnt - 6'h1;
   end
   assign transmit_data = (cnt == 6'h0) ? !hold_low : !cnt[1];
endmodule

/* bench/cftf_fault_flags_monitor.sv */
// Port checker for the fault-flag block.
// Assumes one core_clk domain with async active-high reset.
`timescale 1ns/1ps
module cftf_fault_flags_monitor
   import cftf_pkg::*;
#(
   parameter int DOMINANT_TIMEOUT_CYC = 8,
   parameter int BUS_DOM_CYC          = 8,
   parameter int UV_CYC               = 8
) (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        reset,
   // Mode and wakes
   input wire cftf_mode_t  mode,
   input wire logic        local_wake,
   input wire logic        remote_wake,
   input wire logic        sleep_block,
   input wire logic        gotosleep_block,
   // Pins and flags
   input wire cftf_raw_t   raw,
   input wire logic        fault_indicator_n,
   input wire logic        receive_force_low,
   input wire logic        driver_enable,
   input wire cftf_flags_t flags
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   logic wake_mode;
   logic normal;
   assign normal = (mode == CFTF_MODE_NORMAL);
   assign wake_mode = (mode == CFTF_MODE_STANDBY) || (mode == CFTF_MODE_GOTOSLEEP) || (mode == CFTF_MODE_SLEEP);
   AST_SLEEP_BLOCK: assert property (sleep_block == flags.power_on_flag)
      else $error("sleep block wrong");
   AST_GTS_BLOCK: assert property (gotosleep_block == (flags.wake_request_flag | flags.power_on_flag))
      else $error("go-to-sleep block wrong");
   AST_WAKE_SET: assert property (wake_mode && (local_wake || remote_wake) |=> flags.wake_request_flag)
      else $error("wake request not set");
   AST_WAKE_PINS: assert property (flags.wake_request_flag && wake_mode && $stable(mode) |->
      !fault_indicator_n && receive_force_low) else $error("wake not shown on pins");
   AST_NORMAL_CLEAR: assert property ($past(mode) != CFTF_MODE_NORMAL && normal &&
      !flags.uv_flag[CFTF_UV_BAT] |=> !flags.wake_request_flag && !flags.power_on_flag)
      else $error("normal entry did not clear");
   AST_SOURCE_HOLD: assert property (flags.wake_source_valid && $past(flags.wake_source_valid) |->
      $stable(flags.wake_source_flag)) else $error("wake source changed");
   AST_LEAVE_NORMAL: assert property ($past(mode) == CFTF_MODE_NORMAL && !normal && !local_wake && !remote_wake
      |=> !flags.bus_failure_flag && !flags.wake_source_valid) else $error("leaving normal did not clear");
   AST_SILENT_DRV: assert property (mode == CFTF_MODE_SILENT |-> !driver_enable)
      else $error("driver on in silent");
   AST_THERMAL_DRV: assert property (flags.thermal_shutdown_flag |-> !driver_enable)
      else $error("driver on while hot");
   AST_SHORT_DRV: assert property (flags.tx_rx_short_flag |-> !driver_enable)
      else $error("driver on with short");
   AST_BUS_FAIL_PIN: assert property (flags.bus_failure_flag && normal && $past(mode) == CFTF_MODE_NORMAL
      |-> !fault_indicator_n) else $error("bus failure not on pin");
endmodule
bind cftf_fault_flags cftf_fault_flags_monitor #(.DOMINANT_TIMEOUT_CYC(DOMINANT_TIMEOUT_CYC), .BUS_DOM_CYC(BUS_DOM_CYC),
   .UV_CYC(UV_CYC)) i_mon (.core_clk(core_clk), .reset(reset), .mode(mode), .local_wake(local_wake),
   .remote_wake(remote_wake), .sleep_block(sleep_block), .gotosleep_block(gotosleep_block), .raw(raw),
   .fault_indicator_n(fault_indicator_n), .receive_force_low(receive_force_low), .driver_enable(driver_enable),
   .flags(flags));

/* bench/test_cftf_fault_flags.sv */
// Bench for the fault-flag block: controller model on the far side, expected flags from the rules.
// Assumes qualification counts of 8; raw inputs need three edges to show.
`timescale 1ns/1ps
module test_cftf_fault_flags
   import cftf_pkg::*;
();
   localparam int QC = 8;
   logic core_clk = 1'b0, reset = 1'b1, enable = 1'b0, standby_control_n = 1'b0, start = 1'b0, hold_low = 1'b0;
   logic local_wake = 1'b0, remote_wake = 1'b0, rxd = 1'b1, bshort = 1'b0, bdom = 1'b0, otemp = 1'b0, trec = 1'b0;
   logic [2:0]  sup = 3'h0;
   logic [3:0]  edges = 4'h0;
   logic        txd, sleep_block, gotosleep_block, fault_indicator_n, receive_force_low, driver_enable;
   cftf_mode_t  mode;
   cftf_raw_t   raw_in;
   cftf_flags_t flags;
   int          mismatches = 0, cmp_count = 0, seed = 32'hd53f, i, k;
   always #25 core_clk = !core_clk;
   cftf_ctrl_model i_ctrl (.core_clk(core_clk), .reset(reset), .enable(enable), .standby_control_n(standby_control_n),
      .start(start), .edges(edges), .hold_low(hold_low), .mode(mode), .transmit_data(txd));
   assign raw_in = {txd, rxd, bshort, bdom, otemp, trec, sup};
   cftf_fault_flags #(.DOMINANT_TIMEOUT_CYC(QC), .BUS_DOM_CYC(QC), .UV_CYC(QC)) i_dut (.core_clk(core_clk),
      .reset(reset), .mode(mode), .local_wake(local_wake), .remote_wake(remote_wake), .sleep_block(sleep_block),
      .gotosleep_block(gotosleep_block), .raw(raw_in), .fault_indicator_n(fault_indicator_n),
      .receive_force_low(receive_force_low), .driver_enable(driver_enable), .flags(flags));
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Outputs are read at the falling edge, clear of the launch edge
   task automatic at(input int n);
      cyc(n);
      @(negedge core_clk);
   endtask
   task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] s);
      cmp_count++;
      if (e !== s) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic mode_set(input logic e, input logic s);
      cyc(1);
      enable <= e;
      standby_control_n <= s;
      at(3);
   endtask
   task automatic tx(input logic [3:0] k);
      cyc(1);
      edges <= k;
      start <= 1'b1;
      cyc(1);
      start <= 1'b0;
      at(4 * k + 6);
   endtask
   task automatic wake(input logic loc);
      cyc(1);
      local_wake <= loc;
      remote_wake <= !loc;
      cyc(1);
      local_wake <= 1'b0;
      remote_wake <= 1'b0;
      at(0);
   endtask
   task automatic tally_and_finish();
      if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      cyc(5000);
      mismatches++;
      tally_and_finish();
   end
   initial begin
      cyc(4);
      reset <= 1'b0;
      at(0);
      chk("flags", 3'h0, |flags);
      chk("fault", 3'h1, fault_indicator_n);
      cyc(1);
      sup <= 3'h4;
      at(QC + 10);
      chk("uv", 3'h4, flags.uv_flag);
      chk("fault", 3'h1, fault_indicator_n);
      cyc(1);
      sup <= 3'h0;
      at(6);
      chk("uv", 3'h0, flags.uv_flag);
      chk("pon wake", 3'h3, {flags.power_on_flag, flags.wake_request_flag});
      chk("blocks", 3'h3, {sleep_block, gotosleep_block});
      mode_set(1'b0, 1'b1);
      chk("fault", 3'h0, fault_indicator_n);
      mode_set(1'b1, 1'b1);
      chk("pon wake", 3'h0, {flags.power_on_flag, flags.wake_request_flag});
      for (i = 0; i < 2; i++) begin
         mode_set(1'b0, 1'b0);
         wake(i[0]);
         chk("wake", 3'h6, {flags.wake_request_flag, receive_force_low, fault_indicator_n});
         cyc($unsigned($random(seed)) % 4);
         wake(!i[0]);
         mode_set(1'b1, 1'b1);
         chk("source", !i[0], fault_indicator_n);
         // Random split of the four edges; the source must survive the first part
         k = 1 + $unsigned($random(seed)) % 3;
         tx(4'(k));
         chk("source", !i[0], fault_indicator_n);
         tx(4'(4 - k));
         chk("source", 3'h1, fault_indicator_n);
      end
      wake(1'b1);
      chk("wake", 3'h0, flags.wake_request_flag);
      mode_set(1'b0, 1'b0);
      cyc(1);
      sup <= 3'h2;
      at(6);
      wake(1'b1);
      at(6);
      chk("uv", 3'h0, flags.uv_flag);
      at(10);
      chk("uv", 3'h2, flags.uv_flag);
      chk("wake", 3'h0, flags.wake_request_flag);
      cyc(1);
      sup <= 3'h0;
      at(6);
      chk("uv", 3'h0, flags.uv_flag);
      mode_set(1'b1, 1'b1);
      cyc(1);
      bshort <= 1'b1;
      at(50);
      tx(4'h3);
      chk("bus fail", 3'h0, flags.bus_failure_flag);
      tx(4'h1);
      chk("bus fail", 3'h5, {flags.bus_failure_flag, fault_indicator_n, driver_enable});
      mode_set(1'b0, 1'b1);
      chk("bus fail", 3'h0, flags.bus_failure_flag);
      cyc(1);
      bshort <= 1'b0;
      mode_set(1'b1, 1'b1);
      cyc(1);
      otemp <= 1'b1;
      at(5);
      chk("thermal", 3'h2, {flags.thermal_shutdown_flag, driver_enable});
      mode_set(1'b0, 1'b1);
      chk("local", 3'h0, fault_indicator_n);
      cyc(1);
      otemp <= 1'b0;
      trec <= 1'b1;
      rxd <= 1'b0;
      at(5);
      chk("thermal", 3'h1, {flags.thermal_shutdown_flag, fault_indicator_n});
      cyc(1);
      trec <= 1'b0;
      hold_low <= 1'b1;
      at(QC + 8);
      chk("short", 3'h1, flags.tx_rx_short_flag);
      cyc(1);
      hold_low <= 1'b0;
      rxd <= 1'b1;
      // Let the released pins pass the synchroniser before leaving silent
      at(4);
      chk("short", 3'h1, flags.tx_rx_short_flag);
      mode_set(1'b1, 1'b1);
      chk("short", 3'h0, flags.tx_rx_short_flag);
      cyc(1);
      hold_low <= 1'b1;
      at(QC + 8);
      chk("timeout", 3'h2, {flags.transmit_dominant_timeout_flag, driver_enable});
      cyc(1);
      hold_low <= 1'b0;
      at(4);
      chk("timeout", 3'h3, {flags.transmit_dominant_timeout_flag, driver_enable});
      cyc(1);
      rxd <= 1'b0;
      at(4);
      chk("timeout", 3'h0, flags.transmit_dominant_timeout_flag);
      cyc(1);
      bdom <= 1'b1;
      at(QC + 8);
      chk("clamp", 3'h3, {flags.bus_dominant_clamp_flag, driver_enable});
      cyc(1);
      bdom <= 1'b0;
      rxd <= 1'b1;
      at(5);
      chk("clamp", 3'h0, flags.bus_dominant_clamp_flag);
      tally_and_finish();
   end
endmodule

/* hdl/cftf_fault_flags.sv */
// Fault and wake flag logic of a CAN transceiver, with fault pin and receive override.
// Assumes mode is decoded outside from enable and standby_control_n on core_clk.
// Overview of operation
// - Six flag groups kept; five can show on the fault pin depending on mode.
// - Fault pin low when a visible flag or fault is present, else high.
// - Power-on set on battery recovery, cleared on entering normal mode.
// - Power-on flag blocks sleep entry.
// - Wake request set by a wake only in standby/go-to-sleep/sleep; fault and receive go low.
// - Wake request cleared on normal entry or core/io undervoltage.
// - Setting wake request restarts core and io undervoltage timers.
// - Go-to-sleep blocked while wake request set.
// - First wake source kept; normal mode pin low for local, high for bus.
// - Source shown in normal only; cleared after four edges, leaving normal, core/io undervoltage.
// - Undervoltage flags internal, set after qualification time.
// - Undervoltage cleared on recovery, core/io also on wake; mode logic then resumes selection.
// - Battery return sets power-on and wake request.
// - Bus failure after four persisting transmit cycles in normal; cleared leaving normal.
// - Bus faults qualified after a minimum time.
// - Local failures other than over-temperature detected in normal/silent, shown after normal to silent.
// - Dominant timeout disables driver until next transmit rising edge.
// - Timeout flag cleared on receive low with transmit high or entry to any mode but silent.
// - Transmit-receive short holds driver off until flag clears.
// - Short flag cleared leaving silent or receive low with transmit high.
// - Bus clamp flag keeps driver on; cleared on receive high or leaving silent.
// - Over-temperature disables driver; cleared after cooling plus release condition.
// - Silent mode keeps driver off while receiver mirrors the bus.
`timescale 1ns/1ps
module cftf_fault_flags
   import cftf_pkg::*;
#(
   parameter int DOMINANT_TIMEOUT_CYC = CFTF_DOMINANT_TIMEOUT_CYC,
   parameter int BUS_DOM_CYC          = CFTF_BUS_DOM_CYC,
   parameter int UV_CYC               = CFTF_UV_CYC
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   // Mode and its requests
   input  wire cftf_mode_t mode,
   input  wire logic       local_wake,
   input  wire logic       remote_wake,
   output logic            sleep_block,
   output logic            gotosleep_block,
   // Pins and comparators, asynchronous
   input  wire cftf_raw_t  raw,
   // Outputs
   output logic            fault_indicator_n,
   output logic            receive_force_low,
   output logic            driver_enable,
   output cftf_flags_t     flags
);

   typedef struct packed {
      cftf_raw_t   sync1;
      cftf_raw_t   sync2;
      cftf_mode_t  mode_q;
      logic        tx_q;
      logic        dto_block;
      logic [2:0]  edge_cnt;
      logic [2:0]  fail_cnt;
      cftf_flags_t f;
      logic        fault_n;
   } cftf_state_t;

   cftf_state_t state;
   cftf_state_t next_state;
   cftf_raw_t   in_s;

   logic [CFTF_NUM_UV-1:0] uv_qual;
   logic [CFTF_NUM_UV-1:0] uv_restart;
   logic                   dto_qual;
   logic                   short_qual;
   logic                   dom_qual;
   logic                   bus_fault_qual;

   assign in_s = state.sync2;

   // Qualification timers on synchronised inputs
   generate
      for (genvar i = 0; i < CFTF_NUM_UV; i++) begin : g_uv
         cftf_qual #(.COUNT(UV_CYC)) u_uv (
            .core_clk  (core_clk),
            .reset     (reset),
            .cond      (in_s.supply_low[i]),
            .restart   (uv_restart[i]),
            .qualified (uv_qual[i])
         );
      end
   endgenerate

   // Restart on wake request set, not for the battery supply
   assign uv_restart = {1'b0, {2{next_state.f.wake_request_flag & ~state.f.wake_request_flag}}};

   cftf_qual #(.COUNT(DOMINANT_TIMEOUT_CYC)) u_dto (
      .core_clk  (core_clk),
      .reset     (reset),
      .cond      (~in_s.transmit_data),
      .restart   (1'b0),
      .qualified (dto_qual)
   );

   // Short looks like transmit and receive both held low together
   cftf_qual #(.COUNT(DOMINANT_TIMEOUT_CYC)) u_short (
      .core_clk  (core_clk),
      .reset     (reset),
      .cond      (~in_s.transmit_data & ~in_s.receive_data & ~driver_enable),
      .restart   (1'b0),
      .qualified (short_qual)
   );

   cftf_qual #(.COUNT(BUS_DOM_CYC)) u_dom (
      .core_clk  (core_clk),
      .reset     (reset),
      .cond      (in_s.bus_dominant),
      .restart   (1'b0),
      .qualified (dom_qual)
   );

   cftf_qual #(.COUNT(CFTF_BUS_FAILURE_MIN_CYC)) u_cbf (
      .core_clk  (core_clk),
      .reset     (reset),
      .cond      (in_s.bus_short),
      .restart   (1'b0),
      .qualified (bus_fault_qual)
   );

   logic in_normal;
   logic in_silent;
   logic enter_normal;
   logic leave_normal;
   logic leave_silent;
   logic norm_to_silent;
   logic mode_change;
   logic low_power;
   logic tx_rise;
   logic tx_fall;
   logic release_cond;
   logic core_io_uv_set;
   logic bat_return;
   logic any_wake;
   logic local_any;

   always_comb begin
      next_state       = state;
      next_state.sync1 = raw;
      next_state.sync2 = state.sync1;
      next_state.mode_q = mode;
      next_state.tx_q   = in_s.transmit_data;

      in_normal      = (mode == CFTF_MODE_NORMAL);
      in_silent      = (mode == CFTF_MODE_SILENT);
      mode_change    = (mode != state.mode_q);
      enter_normal   = in_normal && mode_change;
      leave_normal   = (state.mode_q == CFTF_MODE_NORMAL) && !in_normal;
      leave_silent   = (state.mode_q == CFTF_MODE_SILENT) && !in_silent;
      norm_to_silent = in_silent && (state.mode_q == CFTF_MODE_NORMAL);
      low_power      = (mode == CFTF_MODE_STANDBY) || (mode == CFTF_MODE_GOTOSLEEP) ||
                       (mode == CFTF_MODE_SLEEP);
      tx_rise        = in_s.transmit_data && !state.tx_q;
      tx_fall        = !in_s.transmit_data && state.tx_q;
      release_cond   = !in_s.receive_data && in_s.transmit_data;
      core_io_uv_set = (uv_qual[CFTF_UV_CORE] && !state.f.uv_flag[CFTF_UV_CORE]) ||
                       (uv_qual[CFTF_UV_IO] && !state.f.uv_flag[CFTF_UV_IO]);
      bat_return     = state.f.uv_flag[CFTF_UV_BAT] && !in_s.supply_low[CFTF_UV_BAT];
      any_wake       = (local_wake || remote_wake) && low_power;
      local_any      = state.f.transmit_dominant_timeout_flag || state.f.tx_rx_short_flag ||
                       state.f.bus_dominant_clamp_flag || state.f.thermal_shutdown_flag;

      // Supply undervoltage: set after qualification, cleared on recovery, core and io also on wake
      for (int i = 0; i < CFTF_NUM_UV; i++) begin
         if (!in_s.supply_low[i] || (any_wake && i != CFTF_UV_BAT)) begin
            next_state.f.uv_flag[i] = 1'b0;
         end
         if (uv_qual[i] && !(any_wake && i != CFTF_UV_BAT)) begin
            next_state.f.uv_flag[i] = 1'b1;
         end
      end

      // Power-on
      if (enter_normal) begin
         next_state.f.power_on_flag = 1'b0;
      end
      if (bat_return) begin
         next_state.f.power_on_flag = 1'b1;
      end

      // Wake request
      if (enter_normal || core_io_uv_set) begin
         next_state.f.wake_request_flag = 1'b0;
      end
      if (any_wake || bat_return) begin
         next_state.f.wake_request_flag = 1'b1;
      end

      // Wake source: first event only; counter of transmit falling edges in normal
      if (in_normal && state.f.wake_source_valid && tx_fall) begin
         next_state.edge_cnt = state.edge_cnt + 3'h1;
      end
      if ((state.edge_cnt == CFTF_EDGE_COUNT) || leave_normal || core_io_uv_set) begin
         next_state.f.wake_source_valid = 1'b0;
         next_state.edge_cnt            = '0;
      end
      if (any_wake && !state.f.wake_source_valid) begin
         next_state.f.wake_source_valid = 1'b1;
         next_state.f.wake_source_flag  = local_wake;
         next_state.edge_cnt            = '0;
      end

      // Bus failure: count transmit dominant-recessive cycles while the short persists
      if (in_normal && bus_fault_qual) begin
         if (tx_rise && state.fail_cnt != CFTF_EDGE_COUNT) begin
            next_state.fail_cnt = state.fail_cnt + 3'h1;
         end
      end else begin
         next_state.fail_cnt = '0;
      end
      if (leave_normal) begin
         next_state.f.bus_failure_flag = 1'b0;
      end
      if (in_normal && state.fail_cnt == CFTF_EDGE_COUNT) begin
         next_state.f.bus_failure_flag = 1'b1;
      end

      // Local failures
      if (release_cond || (mode_change && !in_silent)) begin
         next_state.f.transmit_dominant_timeout_flag = 1'b0;
      end
      if (release_cond || leave_silent) begin
         next_state.f.tx_rx_short_flag = 1'b0;
      end
      if (in_s.receive_data || leave_silent) begin
         next_state.f.bus_dominant_clamp_flag = 1'b0;
      end
      if (in_s.temp_recovered && (release_cond || (mode_change && !in_silent))) begin
         next_state.f.thermal_shutdown_flag = 1'b0;
      end
      if (in_normal || in_silent) begin
         if (dto_qual) begin
            next_state.f.transmit_dominant_timeout_flag = 1'b1;
         end
         if (short_qual) begin
            next_state.f.tx_rx_short_flag = 1'b1;
         end
         if (dom_qual) begin
            next_state.f.bus_dominant_clamp_flag = 1'b1;
         end
      end
      if (in_s.over_temp) begin
         next_state.f.thermal_shutdown_flag = 1'b1;
      end

      // Dominant timeout latch releases only on a transmit rising edge
      if (tx_rise) begin
         next_state.dto_block = 1'b0;
      end else if (dto_qual) begin
         next_state.dto_block = 1'b1;
      end

      // Indicator visible only after normal to silent; other transitions hide it
      if (norm_to_silent) begin
         next_state.f.local_visible = 1'b1;
      end else if (mode_change) begin
         next_state.f.local_visible = 1'b0;
      end

      // Fault pin selection per mode
      next_state.fault_n = 1'b1;
      if (low_power && next_state.f.wake_request_flag) begin
         next_state.fault_n = 1'b0;
      end else if (in_silent) begin
         if ((next_state.f.local_visible && local_any) ||
             (next_state.f.power_on_flag && state.mode_q != CFTF_MODE_NORMAL)) begin
            next_state.fault_n = 1'b0;
         end
      end else if (in_normal) begin
         if (next_state.f.bus_failure_flag ||
             (next_state.f.wake_source_valid && next_state.f.wake_source_flag)) begin
            next_state.fault_n = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state         <= '0;
         state.mode_q  <= CFTF_MODE_SLEEP;
         state.tx_q    <= 1'b1;
         state.fault_n <= 1'b1;
         state.sync1.transmit_data <= 1'b1;
         state.sync2.transmit_data <= 1'b1;
         state.sync1.receive_data  <= 1'b1;
         state.sync2.receive_data  <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   // Silent mode and thermal, timeout, short faults hold the driver off; the clamp does not
   assign driver_enable = (mode == CFTF_MODE_NORMAL) && !state.dto_block &&
                          !state.f.tx_rx_short_flag && !state.f.thermal_shutdown_flag;
   assign sleep_block       = state.f.power_on_flag;
   assign gotosleep_block   = state.f.wake_request_flag | state.f.power_on_flag;
   assign receive_force_low = state.f.wake_request_flag &&
                              (state.mode_q != CFTF_MODE_NORMAL) && (state.mode_q != CFTF_MODE_SILENT);
   assign fault_indicator_n = state.fault_n;
   assign flags             = state.f;

endmodule

/* hdl/cftf_pkg.sv */
// Package for the transceiver fault-flag block: modes, timing constants, carrier structs.
// Assumes a 20 MHz core_clk; analog comparators and mode decoding live outside.
package cftf_pkg;

   // Operating modes as decoded by the mode logic outside this block
   typedef enum logic [2:0] {
      CFTF_MODE_SLEEP     = 3'h0,
      CFTF_MODE_STANDBY   = 3'h1,
      CFTF_MODE_GOTOSLEEP = 3'h3,
      CFTF_MODE_NORMAL    = 3'h2,
      CFTF_MODE_SILENT    = 3'h6,
      CFTF_MODE_PROTECTED = 3'h7
   } cftf_mode_t;

   localparam int CFTF_CLK_HZ = 20000000;

   // Minimum bus failure qualification, in ns as printed (1.9 us)
   localparam int CFTF_BUS_FAILURE_MIN_TIME_NS = 1900;
   localparam int CFTF_BUS_FAILURE_MIN_CYC     =
      (CFTF_BUS_FAILURE_MIN_TIME_NS * (CFTF_CLK_HZ / 1000000) + 999) / 1000;

   // Default qualification counts for figures the flag logic does not print
   localparam int CFTF_DOMINANT_TIMEOUT_CYC = 20000;
   localparam int CFTF_BUS_DOM_CYC          = 20000;
   localparam int CFTF_UV_CYC               = 200;

   localparam int          CFTF_CNT_W        = 16;
   localparam logic [2:0]  CFTF_EDGE_COUNT   = 3'h4;
   localparam logic [1:0]  CFTF_UV_CORE      = 2'h0;
   localparam logic [1:0]  CFTF_UV_IO        = 2'h1;
   localparam logic [1:0]  CFTF_UV_BAT       = 2'h2;
   localparam int          CFTF_NUM_UV       = 3;
   localparam logic [2:0]  CFTF_UV_RST       = 3'h0;

   // Raw inputs from comparators and pins
   typedef struct packed {
      logic       transmit_data;
      logic       receive_data;
      logic       bus_short;
      logic       bus_dominant;
      logic       over_temp;
      logic       temp_recovered;
      logic [2:0] supply_low;
   } cftf_raw_t;

   // Diagnostic flags
   typedef struct packed {
      logic       power_on_flag;
      logic       wake_request_flag;
      logic       wake_source_valid;
      logic       wake_source_flag;
      logic [2:0] uv_flag;
      logic       bus_failure_flag;
      logic       transmit_dominant_timeout_flag;
      logic       tx_rx_short_flag;
      logic       bus_dominant_clamp_flag;
      logic       thermal_shutdown_flag;
      logic       local_visible;
   } cftf_flags_t;

endpackage

/* hdl/cftf_qual.sv */
// Qualification counter: output rises once the synchronised condition has held for the set count.
// Assumes cond already lives in the core_clk domain; restart forces a fresh count.
`timescale 1ns/1ps
module cftf_qual
   import cftf_pkg::*;
#(
   parameter int COUNT = 4
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   // Condition
   input  wire logic cond,
   input  wire logic restart,
   output logic      qualified
);

   typedef struct packed {
      logic [CFTF_CNT_W-1:0] cnt;
      logic                  hit;
   } cftf_qual_state_t;

   localparam logic [CFTF_CNT_W-1:0] LIMIT = CFTF_CNT_W'(COUNT - 1);

   cftf_qual_state_t state;
   cftf_qual_state_t next_state;

   always_comb begin
      next_state = state;
      if (!cond || restart) begin
         next_state.cnt = '0;
         next_state.hit = 1'b0;
      end else if (state.cnt >= LIMIT) begin
         next_state.hit = 1'b1;
      end else begin
         next_state.cnt = state.cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign qualified = state.hit;

endmodule
